/* File: rtl/wdr_watchdog.sv */
// watchdog timer with timed change sequence and reset-cause flags
`timescale 1ns/10ps
module wdr_watchdog
  import wdr_pkg::*;
(
  // clock and power-on reset
  input  wire logic        clk,
  input  wire logic        rst,
  // watchdog oscillator, fuse and external reset causes
  input  wire logic        wdtOsc,
  input  wire logic        alwaysOnFuse,
  input  wire logic        pinResetReq,
  input  wire logic        brownoutResetReq,
  input  wire logic        scanResetReq,
  // restart instruction strobe from the core
  input  wire logic        wdtRestart,
  // avalon-mm slave
  input  wire wdr_avreq_t  avReq,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // internal reset pulse on timeout
  output logic             wdtResetPulse
);

  logic                 oscMeta_r;
  logic                 oscSync_r;
  logic                 oscPrev_r;
  logic                 fuseMeta_r;
  logic                 fuseLvl2_r;
  logic [2:0]           rstMeta_r;
  logic [2:0]           rstSync_r;
  logic                 waitreq_r;
  logic [31:0]          readdata_r;
  logic [2:0]           winCnt_r;
  logic                 enable_r;
  logic [2:0]           prescale_r;
  logic [WDR_CNT_W-1:0] wdtCnt_r;
  logic                 wdtPulse_r;
  logic [4:0]           flags_r;

  logic                 tick;
  logic                 chipRst;
  logic                 running;
  logic                 ceActive;
  logic                 wrDone;
  logic                 wrCtrl;
  logic                 wrFlag;
  logic                 openWr;
  logic                 accept;
  logic [7:0]           wd;
  logic [7:0]           ctrlView;
  logic [WDR_CNT_W-1:0] lastCnt;
  logic [4:0]           flagClr;
  logic [4:0]           flagSet;

  assign readdata      = readdata_r;
  assign waitrequest   = waitreq_r;
  assign wdtResetPulse = wdtPulse_r;

  // pins pass two flops; the oscillator needs a third for its edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      oscMeta_r <= 1'b0;
      oscSync_r <= 1'b0;
      oscPrev_r <= 1'b0;
    end
    else
    begin
      oscMeta_r <= wdtOsc;
      oscSync_r <= oscMeta_r;
      oscPrev_r <= oscSync_r;
    end
  end

  // oscillator must stay well below half of clk for edges to be seen
  assign tick = oscSync_r & ~oscPrev_r;

  // fuse is caught after release; level 1 is assumed until it settles
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fuseMeta_r <= 1'b0;
      fuseLvl2_r <= 1'b0;
    end
    else
    begin
      fuseMeta_r <= alwaysOnFuse;
      fuseLvl2_r <= fuseMeta_r;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rstMeta_r <= 3'h0;
      rstSync_r <= 3'h0;
    end
    else
    begin
      rstMeta_r <= {scanResetReq, brownoutResetReq, pinResetReq};
      rstSync_r <= rstMeta_r;
    end
  end

  assign chipRst = (|rstSync_r) | wdtPulse_r;
  assign running = enable_r | fuseLvl2_r;
  assign ceActive = (winCnt_r != 3'h0);

  // bus decode: a write lands on the edge that sees waitrequest low
  assign wd     = avReq.writedata[7:0];
  assign wrDone = avReq.write & ~waitreq_r & avReq.byteenable[0];
  assign wrCtrl = wrDone & (avReq.address == WDR_CTRL_OFS);
  assign wrFlag = wrDone & (avReq.address == WDR_FLAG_OFS);
  assign openWr = wrCtrl & wd[WDR_CE_BIT] & wd[WDR_EN_BIT];
  assign accept = wrCtrl & ceActive & ~wd[WDR_CE_BIT];

  assign ctrlView = {3'h0, ceActive, running, prescale_r};

  // one wait cycle on every access, then one cycle of completion
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      waitreq_r <= 1'b1;
    else if ((avReq.read | avReq.write) & waitreq_r)
      waitreq_r <= 1'b0;
    else
      waitreq_r <= 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      readdata_r <= 32'h0;
    else if (avReq.read & waitreq_r)
    begin
      if (avReq.address == WDR_CTRL_OFS)
        readdata_r <= {24'h0, ctrlView};
      else if (avReq.address == WDR_FLAG_OFS)
        readdata_r <= {27'h0, flags_r};
      else
        readdata_r <= 32'h0;
    end
  end

  // change window; closed by the accepted write so one open, one change
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      winCnt_r <= 3'h0;
    else if (chipRst)
      winCnt_r <= 3'h0;
    else if (openWr)
      winCnt_r <= WDR_CE_CYCLES;
    else if (accept)
      winCnt_r <= 3'h0;
    else if (ceActive)
      winCnt_r <= winCnt_r - 3'h1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      enable_r <= 1'b0;
    else if (chipRst)
      enable_r <= 1'b0;
    else if (wrCtrl & wd[WDR_EN_BIT])
      enable_r <= 1'b1;
    else if (accept)
      enable_r <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prescale_r <= WDR_PS_RST;
    else if (chipRst)
      prescale_r <= WDR_PS_RST;
    else if (accept)
      prescale_r <= wd[WDR_PS_LSB +: 3];
  end

  // last count before timeout: 2^(14+code) - 1
  assign lastCnt = WDR_CNT_W'((32'h1 << (WDR_BASE_SHIFT + 32'(prescale_r)))
                   - 32'h1);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wdtCnt_r <= '0;
    else if (chipRst | wdtRestart | ~running)
      wdtCnt_r <= '0;
    else if (tick)
    begin
      if (wdtCnt_r >= lastCnt)
        wdtCnt_r <= '0;
      else
        wdtCnt_r <= wdtCnt_r + WDR_CNT_W'(1);
    end
  end

  // a shortened timeout leaves the counter past the new limit: fire then
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wdtPulse_r <= 1'b0;
    else
      wdtPulse_r <= running & tick & (wdtCnt_r >= lastCnt) & ~chipRst
                    & ~wdtRestart;
  end

  // set beats a clear written in the same cycle
  assign flagClr = wrFlag ? ~wd[4:0] : 5'h0;
  assign flagSet = {rstSync_r[2], wdtPulse_r, rstSync_r[1], rstSync_r[0],
                    1'b0};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flags_r <= WDR_FLAG_RST;
    else
      flags_r <= (flags_r & ~flagClr) | flagSet;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence openSeq;
    openWr && !chipRst;
  endsequence

  sequence quietBus4;
    (!wrCtrl && !chipRst)[*4];
  endsequence

  sequence keepWin2;
    (!accept && !chipRst)[*2];
  endsequence

  pulse_width_a: assert property (
    wdtPulse_r |=> !wdtPulse_r)
    else $error("timeout pulse wider than one cycle");

  timeout_flag_a: assert property (
    wdtPulse_r |=> flags_r[WDR_TO_BIT])
    else $error("watchdog flag not set after timeout");

  lvl2_enable_a: assert property (
    fuseLvl2_r |-> ctrlView[WDR_EN_BIT] && running)
    else $error("enable not reading one at level two");

  reserved_zero_a: assert property (
    (!waitreq_r && avReq.read && avReq.address == WDR_CTRL_OFS)
      |-> readdata_r[31:5] == 27'h0)
    else $error("reserved control bits not zero");

  ce_autoclr_a: assert property (
    openSeq ##1 quietBus4 |=> !ceActive)
    else $error("change enable not cleared after four cycles");

  ce_open_a: assert property (
    openSeq ##1 keepWin2 |-> $past(ceActive) && ceActive ##1 ceActive)
    else $error("change window shorter than expected");

  ps_guard_a: assert property (
    (!ceActive && !chipRst) |=> $stable(prescale_r))
    else $error("prescale changed outside change window");

  dis_guard_a: assert property (
    (!ceActive && !chipRst) |=> !$fell(enable_r))
    else $error("watchdog disabled without change enable");

  restart_clr_a: assert property (
    (wdtRestart || chipRst) |=> wdtCnt_r == '0)
    else $error("counter not cleared by restart or reset");

  por_flag_a: assert property (
    (flags_r[WDR_POR_BIT] && !(wrFlag && !wd[WDR_POR_BIT]))
      |=> flags_r[WDR_POR_BIT])
    else $error("power-on flag lost without software clear");

  en_write_a: assert property (
    (wrCtrl && wd[WDR_EN_BIT] && !chipRst) |=> enable_r)
    else $error("enable write did not enable the watchdog");

  open_ps_a: assert property (
    (openWr && !chipRst) |=> $stable(prescale_r))
    else $error("opening write changed the prescale");

  accept_ps_a: assert property (
    (accept && !chipRst)
      |=> prescale_r == $past(wd[WDR_PS_LSB +: 3]))
    else $error("accepted write did not set the prescale");

  ce_drop_a: assert property (
    accept |=> !ceActive)
    else $error("change window still open after the change");

  lvl1_off_a: assert property (
    (accept && !wd[WDR_EN_BIT] && !fuseMeta_r && !fuseLvl2_r)
      |=> !running)
    else $error("disable sequence did not stop the watchdog");

  lvl2_on_a: assert property (
    (accept && fuseMeta_r && fuseLvl2_r) |=> running)
    else $error("watchdog stopped at level two");

  lvl2_read_a: assert property (
    (avReq.read && waitreq_r && avReq.address == WDR_CTRL_OFS
      && fuseLvl2_r) |=> readdata_r[WDR_EN_BIT])
    else $error("enable read back as zero at level two");

  lvl2_run_a: assert property (
    (fuseLvl2_r && tick && !chipRst && !wdtRestart
      && wdtCnt_r < lastCnt)
      |=> wdtCnt_r == $past(wdtCnt_r) + WDR_CNT_W'(1))
    else $error("counter not advancing at level two");

  cnt_off_a: assert property (
    !running |=> wdtCnt_r == '0)
    else $error("counter not held clear while disabled");

  pulse_cause_a: assert property (
    wdtPulse_r |-> $past(running) && $past(tick))
    else $error("timeout pulse without a running tick");

  pulse_clr_a: assert property (
    wdtPulse_r |=> wdtCnt_r == '0 && !enable_r && !ceActive)
    else $error("timeout reset left state behind");

  pin_flag_a: assert property (
    rstSync_r[0] |=> flags_r[WDR_PIN_BIT])
    else $error("pin reset flag not set");

  bo_flag_a: assert property (
    rstSync_r[1] |=> flags_r[WDR_BO_BIT])
    else $error("brown-out reset flag not set");

  scan_flag_a: assert property (
    rstSync_r[2] |=> flags_r[WDR_SCAN_BIT])
    else $error("scan reset flag not set");

  to_hold_a: assert property (
    (flags_r[WDR_TO_BIT] && !(wrFlag && !wd[WDR_TO_BIT]))
      |=> flags_r[WDR_TO_BIT])
    else $error("watchdog flag lost without software clear");

endmodule

/* File: rtl/wdr_pkg.sv */
// constants and carrier types of the watchdog with reset-cause flags
package wdr_pkg;

  // register byte offsets on the avalon slave
  localparam logic [2:0] WDR_CTRL_OFS = 3'h0;
  localparam logic [2:0] WDR_FLAG_OFS = 3'h4;

  // watchdog_control field positions
  localparam int         WDR_PS_LSB = 0;
  localparam int         WDR_EN_BIT = 3;
  localparam int         WDR_CE_BIT = 4;

  // reset_cause_flags field positions
  localparam int         WDR_POR_BIT  = 0;
  localparam int         WDR_PIN_BIT  = 1;
  localparam int         WDR_BO_BIT   = 2;
  localparam int         WDR_TO_BIT   = 3;
  localparam int         WDR_SCAN_BIT = 4;

  // values after reset
  localparam logic [2:0] WDR_PS_RST   = 3'h0;
  localparam logic [4:0] WDR_FLAG_RST = 5'h01;

  // change window length in system clock cycles
  localparam logic [2:0] WDR_CE_CYCLES = 3'h4;

  // timeout counter: 16K oscillator cycles at code zero, doubling per code
  localparam int         WDR_CNT_W      = 21;
  localparam int         WDR_BASE_SHIFT = 14;

  // nominal rates, for reference of the timeout figures
  localparam int         WDR_OSC_HZ = 1000000;
  localparam int         WDR_SYS_HZ = 20000000;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [2:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } wdr_avreq_t;

endpackage

/* File: testbench/tb_top.sv */
// self-checking bench for the watchdog and reset-cause flags
`timescale 1ns/10ps
module tb_top;
  import wdr_pkg::*;
  logic        clk;
  logic        rst;
  logic        wdtOsc;
  logic        alwaysOnFuse;
  logic        pinResetReq;
  logic        brownoutResetReq;
  logic        scanResetReq;
  logic        wdtRestart;
  wdr_avreq_t  avReq;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        wdtResetPulse;
  logic [31:0] q;
  int          numErrors;
  int          numChecks;
  int          cnt;

  wdr_watchdog uut (
    .clk              (clk),
    .rst              (rst),
    .wdtOsc           (wdtOsc),
    .alwaysOnFuse     (alwaysOnFuse),
    .pinResetReq      (pinResetReq),
    .brownoutResetReq (brownoutResetReq),
    .scanResetReq     (scanResetReq),
    .wdtRestart       (wdtRestart),
    .avReq            (avReq),
    .readdata         (readdata),
    .waitrequest      (waitrequest),
    .wdtResetPulse    (wdtResetPulse)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // fast oscillator, unrelated phase, so timeouts fit in a short run
  initial
  begin
    wdtOsc = 1'b0;
    #13;
    forever #50 wdtOsc = ~wdtOsc;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      numErrors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [2:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    avReq <= '{read: ~wr, write: wr, address: a,
               writedata: {24'h0, d}, byteenable: 4'hf};
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    avReq <= '0;
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic test_reset_values();
    bus(1'b0, WDR_CTRL_OFS, 8'h00);
    chk(q, 32'h0);
    bus(1'b0, WDR_FLAG_OFS, 8'h00);
    chk(q, 32'h1);
    bus(1'b1, 3'h2, 8'hff);
    bus(1'b0, 3'h2, 8'h00);
    chk(q, 32'h0);
    $display("reset values done");
  endtask

  task automatic test_enable_guard();
    bus(1'b1, WDR_CTRL_OFS, 8'hff);
    bus(1'b0, WDR_CTRL_OFS, 8'h00);
    chk(q, 32'h18);
    bus(1'b1, WDR_CTRL_OFS, 8'h00);
    bus(1'b0, WDR_CTRL_OFS, 8'h00);
    chk(q, 32'h08);
    bus(1'b1, WDR_CTRL_OFS, 8'h18);
    repeat (6) @(posedge clk);
    bus(1'b1, WDR_CTRL_OFS, 8'h05);
    bus(1'b0, WDR_CTRL_OFS, 8'h00);
    chk(q, 32'h08);
    bus(1'b1, WDR_CTRL_OFS, 8'h18);
    bus(1'b1, WDR_CTRL_OFS, 8'h03);
    bus(1'b0, WDR_CTRL_OFS, 8'h00);
    chk(q, 32'h03);
    $display("enable guard done");
  endtask

  task automatic test_flags();
    logic [7:0] exp [3] = '{8'h02, 8'h04, 8'h10};
    bus(1'b1, WDR_FLAG_OFS, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, WDR_CTRL_OFS, 8'h08);
      @(posedge clk);
      {scanResetReq, brownoutResetReq, pinResetReq} <= 3'b001 << i;
      repeat (3) @(posedge clk);
      {scanResetReq, brownoutResetReq, pinResetReq} <= 3'b000;
      repeat (4) @(posedge clk);
      bus(1'b0, WDR_FLAG_OFS, 8'h00);
      chk(q, {24'h0, exp[i]});
      bus(1'b0, WDR_CTRL_OFS, 8'h00);
      chk(q, 32'h0);
      bus(1'b1, WDR_FLAG_OFS, 8'h00);
    end
    $display("flags done");
  endtask

  task automatic test_timeout();
    bus(1'b1, WDR_CTRL_OFS, 8'h08);
    repeat (16000) @(posedge clk);
    wdtRestart <= 1'b1;
    @(posedge clk);
    wdtRestart <= 1'b0;
    cnt = 0;
    while (wdtResetPulse !== 1'b1 && cnt < 40000)
    begin
      @(posedge clk);
      cnt++;
    end
    // 16K ticks at two clocks per tick after the restart
    chk({31'h0, cnt > 32000 && cnt < 33500}, 32'h1);
    @(posedge clk);
    chk({31'h0, wdtResetPulse}, 32'h0);
    repeat (3) @(posedge clk);
    bus(1'b0, WDR_FLAG_OFS, 8'h00);
    chk(q, 32'h08);
    bus(1'b0, WDR_CTRL_OFS, 8'h00);
    chk(q, 32'h0);
    $display("timeout done");
  endtask

  task automatic test_level2();
    alwaysOnFuse <= 1'b1;
    do_reset();
    bus(1'b0, WDR_CTRL_OFS, 8'h00);
    chk(q, 32'h08);
    bus(1'b0, WDR_FLAG_OFS, 8'h00);
    chk(q, 32'h01);
    bus(1'b1, WDR_CTRL_OFS, 8'h18);
    bus(1'b1, WDR_CTRL_OFS, 8'h02);
    bus(1'b0, WDR_CTRL_OFS, 8'h00);
    chk(q, 32'h0a);
    $display("level two done");
  endtask

  initial
  begin
    numErrors = 0;
    numChecks = 0;
    rst = 1'b1;
    alwaysOnFuse = 1'b0;
    pinResetReq = 1'b0;
    brownoutResetReq = 1'b0;
    scanResetReq = 1'b0;
    wdtRestart = 1'b0;
    avReq = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    test_reset_values();
    test_enable_guard();
    test_flags();
    test_timeout();
    test_level2();
    reportAndStop();
  end

  // the longest scenario takes about 50k cycles
  initial
  begin
    repeat (90000) @(posedge clk);
    numErrors++;
    reportAndStop();
  end
endmodule
